// ---- include/watchdog_pkg.sv ----
package watchdog_pkg;

  // bus geometry: one address bit selects the frame, the low bits are the frame offset
  localparam int ADDR_W = 13;
  localparam int OFS_W = 12;
  localparam int FRAME_BIT = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // frame select values
  localparam logic FRAME_REFRESH = 1'b0;
  localparam logic FRAME_CONTROL = 1'b1;

  // refresh frame offsets
  localparam logic [OFS_W-1:0] OFS_REFRESH_TRIGGER = 12'h000;
  localparam logic [OFS_W-1:0] OFS_REFRESH_FRAME_IDENT = 12'hfcc;

  // control frame offsets
  localparam logic [OFS_W-1:0] OFS_CONTROL_AND_ALERT_STATUS = 12'h000;
  localparam logic [OFS_W-1:0] OFS_TIMEOUT_OFFSET_LOW = 12'h008;
  localparam logic [OFS_W-1:0] OFS_TIMEOUT_OFFSET_HIGH = 12'h00c;
  localparam logic [OFS_W-1:0] OFS_COMPARE_VALUE_LOW = 12'h010;
  localparam logic [OFS_W-1:0] OFS_COMPARE_VALUE_HIGH = 12'h014;
  localparam logic [OFS_W-1:0] OFS_CONTROL_FRAME_IDENT = 12'hfcc;

  // widths of the watch state
  localparam int COUNT_W = 64;
  localparam int OFFSET_W = 48;
  localparam int OFFSET_HI_W = 16;

  // control and status field positions
  localparam int CS_ENABLE_BIT = 0;
  localparam int CS_FIRST_BIT = 1;
  localparam int CS_SECOND_BIT = 2;

  // cold reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [OFFSET_W-1:0] RST_OFFSET = 48'h0000_0000_0000;
  localparam logic [COUNT_W-1:0] RST_COMPARE = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage : watchdog_pkg

// ---- src/two_stage_watchdog.sv ----
// Behaviour
// RQ1: cold reset only at power-up, restores registers
// RQ2: warm reset touches only the bus interface
// RQ3: timeout when counter exceeds 64-bit compare
// RQ4: explicit refresh loads counter plus offset
// RQ5: offset is 48 bits, zero-extended
// RQ6: timeout with first alert low reloads compare
// RQ7: writes to refresh/offset/control are explicit refreshes
// RQ8: explicit refresh clears alerts; timeout never does
// RQ9: timeout with first alert high keeps compare
// RQ10: timeout with no alerts raises first alert
// RQ11: timeout with first alert raises second alert
// RQ12: alerts stick until explicit refresh or cold reset
// RQ13: disabled watchdog forces both alerts low
// RQ14: direct compare write beats refresh reload
// RQ15: alert states readable in control register
// RQ16: software disables watchdog before counter updates
// RQ17: 32-bit little-endian registers, 32-bit accesses
// RQ18: refresh register reads zero, write refreshes
// RQ19: upper offset word holds bits 47:32 only
// RQ20: two frames, ident register at same offset
// RQ21: enable clears on cold reset
// RQ22: bit0 enable, bit1 first, bit2 second alert
// RQ23: control bits 31:3 read zero
// RQ24: registered alerts, explicit refresh beats timeout
// RQ25: compare and reload use same counter sample
`timescale 1ns/100ps

module two_stage_watchdog #(
  // identification word; every field value here is arbitrary
  parameter logic [31:0] IDENT_VALUE = 32'h0001_0000
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic WARM_RST_N_I,
  input wire logic [watchdog_pkg::COUNT_W-1:0] SYS_COUNT_I,
  input wire logic [watchdog_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [watchdog_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [watchdog_pkg::BE_W-1:0] AVS_BYTEENABLE_I,
  output logic [watchdog_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic FIRST_STAGE_ALERT_O,
  output logic SECOND_STAGE_ALERT_O
);
  import watchdog_pkg::*;

  typedef struct packed {
    bus_state_t bus;
    logic wait_req;
    logic [DATA_W-1:0] rdata;
    logic enable;
    logic first_stage_alert;
    logic second_stage_alert;
    logic [OFFSET_W-1:0] offset;
    logic [COUNT_W-1:0] compare_value;
  } state_t;

  state_t s_q;
  state_t s_d;

  // byte-lane merge; partial writes are honoured lane by lane
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // request decode
  logic frame_sel;
  logic [OFS_W-1:0] ofs;
  logic wr_fire;
  logic rd_start;
  logic timeout;
  logic explicit_refresh;
  logic compare_write;
  logic enable_next;
  logic [COUNT_W-1:0] reload_value;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] cs_value;
  logic [DATA_W-1:0] ofs_hi_value;
  logic [DATA_W-1:0] ofs_hi_merged;

  assign frame_sel = AVS_ADDRESS_I[FRAME_BIT];
  assign ofs = AVS_ADDRESS_I[OFS_W-1:0];
  // a write takes effect only at the edge where waitrequest is seen low
  assign wr_fire = AVS_WRITE_I && (s_q.bus == BUS_ACK); // RQ17
  assign rd_start = (AVS_READ_I || AVS_WRITE_I) && (s_q.bus == BUS_IDLE);
  // one counter sample feeds both the compare and the reload sum
  assign timeout = SYS_COUNT_I > s_q.compare_value; // RQ3 RQ25
  assign cs_value = {29'h0000_0000, s_q.second_stage_alert, s_q.first_stage_alert,
                     s_q.enable}; // RQ15 RQ22 RQ23
  assign ofs_hi_value = {16'h0000, s_q.offset[OFFSET_W-1:32]}; // RQ19
  // merged upper word; only its low half is kept, so bits 31:16 ignore writes
  assign ofs_hi_merged = merge(ofs_hi_value, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

  // read mux; unmapped and reserved words read as zero
  always_comb begin
    read_value = READ_ZERO;
    if (frame_sel == FRAME_REFRESH) begin
      case (ofs)
        OFS_REFRESH_TRIGGER: read_value = READ_ZERO; // RQ18
        OFS_REFRESH_FRAME_IDENT: read_value = IDENT_VALUE; // RQ20
        default: read_value = READ_ZERO;
      endcase
    end else begin
      case (ofs)
        OFS_CONTROL_AND_ALERT_STATUS: read_value = cs_value;
        OFS_TIMEOUT_OFFSET_LOW: read_value = s_q.offset[31:0];
        OFS_TIMEOUT_OFFSET_HIGH: read_value = ofs_hi_value;
        OFS_COMPARE_VALUE_LOW: read_value = s_q.compare_value[31:0];
        OFS_COMPARE_VALUE_HIGH: read_value = s_q.compare_value[63:32];
        OFS_CONTROL_FRAME_IDENT: read_value = IDENT_VALUE; // RQ20
        default: read_value = READ_ZERO;
      endcase
    end
  end

  // explicit refresh sources: refresh word, either offset word, control word
  always_comb begin
    explicit_refresh = 1'b0;
    compare_write = 1'b0;
    if (wr_fire) begin
      if (frame_sel == FRAME_REFRESH) begin
        explicit_refresh = (ofs == OFS_REFRESH_TRIGGER); // RQ7 RQ18
      end else begin
        explicit_refresh = (ofs == OFS_CONTROL_AND_ALERT_STATUS) ||
                           (ofs == OFS_TIMEOUT_OFFSET_LOW) ||
                           (ofs == OFS_TIMEOUT_OFFSET_HIGH); // RQ7
        compare_write = (ofs == OFS_COMPARE_VALUE_LOW) ||
                        (ofs == OFS_COMPARE_VALUE_HIGH);
      end
    end
  end

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    enable_next = s_q.enable;
    reload_value = RST_COMPARE;

    // bus handshake: one wait cycle, then a single ready cycle
    case (s_q.bus)
      BUS_IDLE: begin
        if (rd_start) begin
          s_d.bus = BUS_ACK;
          s_d.wait_req = 1'b0;
          s_d.rdata = read_value; // held through the ready cycle
        end
      end
      BUS_ACK: begin
        s_d.bus = BUS_IDLE;
        s_d.wait_req = 1'b1;
      end
      default: begin
        s_d.bus = BUS_IDLE;
        s_d.wait_req = 1'b1;
      end
    endcase

    // register writes; the new offset is already used by the reload below
    if (wr_fire && frame_sel == FRAME_CONTROL) begin
      case (ofs)
        OFS_CONTROL_AND_ALERT_STATUS: begin
          if (AVS_BYTEENABLE_I[0]) begin
            enable_next = AVS_WRITEDATA_I[CS_ENABLE_BIT]; // RQ22
          end
        end
        OFS_TIMEOUT_OFFSET_LOW: begin
          s_d.offset[31:0] = merge(s_q.offset[31:0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end
        OFS_TIMEOUT_OFFSET_HIGH: begin
          s_d.offset[OFFSET_W-1:32] = ofs_hi_merged[OFFSET_HI_W-1:0]; // RQ19
        end
        default: begin
        end
      endcase
    end
    s_d.enable = enable_next;

    // compare value: direct load first, else refresh-driven reload
    reload_value = SYS_COUNT_I + {16'h0000, s_d.offset}; // RQ4 RQ5 RQ25
    if (compare_write) begin
      if (ofs == OFS_COMPARE_VALUE_LOW) begin // RQ14
        s_d.compare_value[31:0] = merge(s_q.compare_value[31:0], AVS_WRITEDATA_I,
                                        AVS_BYTEENABLE_I);
      end else begin
        s_d.compare_value[63:32] = merge(s_q.compare_value[63:32], AVS_WRITEDATA_I,
                                         AVS_BYTEENABLE_I);
      end
    end else if (explicit_refresh) begin
      s_d.compare_value = reload_value; // RQ4
    end else if (timeout && !s_q.first_stage_alert) begin // RQ9
      s_d.compare_value = reload_value; // RQ6
    end
    // a timeout with the first alert up leaves the compare as the second-alert time

    // alerts: disable beats explicit refresh, which beats timeout
    if (!enable_next) begin
      s_d.first_stage_alert = 1'b0; // RQ13
      s_d.second_stage_alert = 1'b0; // RQ13
    end else if (explicit_refresh) begin
      s_d.first_stage_alert = 1'b0; // RQ8 RQ24
      s_d.second_stage_alert = 1'b0; // RQ8 RQ24
    end else if (timeout) begin // RQ12
      if (!s_q.first_stage_alert) begin
        s_d.first_stage_alert = 1'b1; // RQ10
      end else begin
        s_d.second_stage_alert = 1'b1; // RQ11
      end
    end

    // warm reset only restarts the bus side; watch state survives
    if (!WARM_RST_N_I) begin // RQ2
      s_d.bus = BUS_IDLE;
      s_d.wait_req = 1'b1;
      s_d.rdata = RST_RDATA;
    end
  end

  // cold reset is the asynchronous power-up reset
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin // RQ1
      s_q.bus <= BUS_IDLE;
      s_q.wait_req <= 1'b1;
      s_q.rdata <= RST_RDATA;
      s_q.enable <= RST_ENABLE; // RQ21
      s_q.first_stage_alert <= 1'b0;
      s_q.second_stage_alert <= 1'b0;
      s_q.offset <= RST_OFFSET;
      s_q.compare_value <= RST_COMPARE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops, so alerts cannot glitch
  assign AVS_READDATA_O = s_q.rdata;
  assign AVS_WAITREQUEST_O = s_q.wait_req;
  assign FIRST_STAGE_ALERT_O = s_q.first_stage_alert; // RQ24
  assign SECOND_STAGE_ALERT_O = s_q.second_stage_alert; // RQ24

  // checks
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  AST_FIRST_RISES: assert property ( // RQ10
    enable_next && !explicit_refresh && timeout && !s_q.first_stage_alert
    |=> FIRST_STAGE_ALERT_O && !$past(SECOND_STAGE_ALERT_O) == !SECOND_STAGE_ALERT_O)
    else $error("first alert did not rise on timeout");

  AST_SECOND_RISES: assert property ( // RQ11
    enable_next && !explicit_refresh && timeout && s_q.first_stage_alert
    |=> SECOND_STAGE_ALERT_O && FIRST_STAGE_ALERT_O)
    else $error("second alert did not rise on timeout");

  AST_DISABLED_QUIET: assert property ( // RQ13
    !s_q.enable |-> !FIRST_STAGE_ALERT_O && !SECOND_STAGE_ALERT_O)
    else $error("alert high while disabled");

  AST_EXPLICIT_CLEARS: assert property ( // RQ8
    explicit_refresh |=> !FIRST_STAGE_ALERT_O && !SECOND_STAGE_ALERT_O)
    else $error("explicit refresh left an alert high");

  AST_ALERT_STICKS: assert property ( // RQ12
    s_q.first_stage_alert && enable_next && !explicit_refresh
    |=> FIRST_STAGE_ALERT_O [*1] ##0 (SECOND_STAGE_ALERT_O || !$past(SECOND_STAGE_ALERT_O)))
    else $error("alert dropped without explicit refresh");

  AST_RELOAD_SUM: assert property ( // RQ4
    explicit_refresh && !compare_write
    |=> s_q.compare_value == $past(SYS_COUNT_I) + {16'h0000, s_q.offset})
    else $error("compare not loaded with counter plus offset");

  AST_KEEP_COMPARE: assert property ( // RQ9
    timeout && s_q.first_stage_alert && !explicit_refresh && !compare_write
    |=> $stable(s_q.compare_value))
    else $error("compare moved on second timeout");

  AST_REFRESH_READS_ZERO: assert property ( // RQ18
    AVS_READ_I && rd_start && WARM_RST_N_I && frame_sel == FRAME_REFRESH &&
    ofs == OFS_REFRESH_TRIGGER |=> !AVS_WAITREQUEST_O && AVS_READDATA_O == READ_ZERO)
    else $error("refresh register read not zero");

  AST_ONE_WAIT: assert property ( // RQ17
    rd_start && WARM_RST_N_I |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer not after exactly one wait cycle");

  AST_RESERVED_ZERO: assert property ( // RQ23
    AVS_READ_I && rd_start && WARM_RST_N_I && frame_sel == FRAME_CONTROL &&
    ofs == OFS_CONTROL_AND_ALERT_STATUS |=> AVS_READDATA_O[31:3] == 29'h0000_0000)
    else $error("reserved control bits not zero");

  // register map, reset, bus side, compare and alert checks
  AST_WARM_KEEPS: assert property ( // RQ2
    !WARM_RST_N_I && !wr_fire
    |=> $stable(s_q.enable) && $stable(s_q.offset) && !$fell(FIRST_STAGE_ALERT_O) &&
    !$fell(SECOND_STAGE_ALERT_O))
    else $error("warm reset disturbed the watch state");

  AST_OFFSET_HIGH_READ: assert property ( // RQ19
    AVS_READ_I && rd_start && WARM_RST_N_I && frame_sel == FRAME_CONTROL &&
    ofs == OFS_TIMEOUT_OFFSET_HIGH |=> AVS_READDATA_O[31:16] == 16'h0000)
    else $error("upper offset word reserved bits not zero");

  AST_IDENT_READ: assert property ( // RQ20
    AVS_READ_I && rd_start && WARM_RST_N_I && ofs == OFS_CONTROL_FRAME_IDENT
    |=> AVS_READDATA_O == IDENT_VALUE)
    else $error("identification word wrong in one frame");

  AST_STATUS_MIRRORS: assert property ( // RQ15
    AVS_READ_I && rd_start && WARM_RST_N_I && frame_sel == FRAME_CONTROL &&
    ofs == OFS_CONTROL_AND_ALERT_STATUS
    |=> AVS_READDATA_O[2:0] == {$past(SECOND_STAGE_ALERT_O), $past(FIRST_STAGE_ALERT_O), $past(s_q.enable)})
    else $error("status bits do not mirror enable and alerts");

  AST_COLD_DEFAULTS: assert property ( // RQ21
    $rose(RST_N_I) |-> !s_q.enable && !FIRST_STAGE_ALERT_O && !SECOND_STAGE_ALERT_O &&
    AVS_WAITREQUEST_O)
    else $error("state after cold reset not at defaults");

  AST_TIMEOUT_RELOADS: assert property ( // RQ6
    timeout && !s_q.first_stage_alert && !explicit_refresh && !compare_write
    |=> s_q.compare_value == $past(SYS_COUNT_I) + {16'h0000, s_q.offset})
    else $error("compare not reloaded on first timeout");

  AST_DIRECT_LOAD: assert property ( // RQ14
    compare_write && ofs == OFS_COMPARE_VALUE_LOW && AVS_BYTEENABLE_I == 4'hf
    |=> s_q.compare_value == {$past(s_q.compare_value[63:32]), $past(AVS_WRITEDATA_I)})
    else $error("direct compare write lost to a reload");

  AST_SECOND_NEEDS_FIRST: assert property ( // RQ11
    SECOND_STAGE_ALERT_O |-> FIRST_STAGE_ALERT_O)
    else $error("second alert high without first");

  AST_FIRST_NEEDS_TIMEOUT: assert property ( // RQ10
    !FIRST_STAGE_ALERT_O && !timeout |=> !FIRST_STAGE_ALERT_O)
    else $error("first alert rose without a timeout");

  AST_ENABLE_WRITE: assert property ( // RQ22
    wr_fire && frame_sel == FRAME_CONTROL && ofs == OFS_CONTROL_AND_ALERT_STATUS &&
    AVS_BYTEENABLE_I[0] |=> s_q.enable == $past(AVS_WRITEDATA_I[CS_ENABLE_BIT]))
    else $error("enable bit not written");

  AST_OFFSET_LOW_WRITE: assert property ( // RQ5
    wr_fire && frame_sel == FRAME_CONTROL && ofs == OFS_TIMEOUT_OFFSET_LOW &&
    AVS_BYTEENABLE_I == 4'hf |=> s_q.offset[31:0] == $past(AVS_WRITEDATA_I))
    else $error("lower offset word not written");

  AST_OFFSET_HIGH_WRITE: assert property ( // RQ19
    wr_fire && frame_sel == FRAME_CONTROL && ofs == OFS_TIMEOUT_OFFSET_HIGH &&
    AVS_BYTEENABLE_I == 4'hf |=> s_q.offset[OFFSET_W-1:32] == $past(AVS_WRITEDATA_I[15:0]))
    else $error("upper offset bits not written");

  AST_REFRESH_WORD_WRITE: assert property ( // RQ7
    wr_fire && frame_sel == FRAME_REFRESH && ofs == OFS_REFRESH_TRIGGER
    |=> s_q.compare_value == $past(SYS_COUNT_I) + {16'h0000, s_q.offset} &&
    !FIRST_STAGE_ALERT_O && !SECOND_STAGE_ALERT_O)
    else $error("refresh word write did not refresh");

  AST_READ_NO_EFFECT: assert property ( // RQ18
    AVS_READ_I && !AVS_WRITE_I && !timeout
    |=> $stable(s_q.compare_value) && $stable(s_q.offset) && $stable(s_q.enable))
    else $error("read changed the watch state");

  AST_DATA_STANDS: assert property ( // RQ17
    s_q.bus == BUS_ACK && WARM_RST_N_I |=> $stable(AVS_READDATA_O))
    else $error("read data moved right after the answer");

endmodule : two_stage_watchdog

// ---- verif/system_counter_model.sv ----
`timescale 1ns/100ps

// stands in for the platform timebase; it holds its value unless told to load or run,
// so every compare value the bench expects can be worked out exactly
module system_counter_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [watchdog_pkg::COUNT_W-1:0] load_value_i,
  input wire logic run_i,
  output logic [watchdog_pkg::COUNT_W-1:0] count_o
);
  import watchdog_pkg::*;

  // a load is only requested by the bench while the watchdog is disabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 64'h0000_0000_0000_0000;
    end else if (load_i) begin
      count_o <= load_value_i;
    end else if (run_i) begin
      count_o <= count_o + 64'h0000_0000_0000_0001;
    end
  end
endmodule : system_counter_model

// ---- verif/two_stage_watchdog_tb.sv ----
`timescale 1ns/100ps

module two_stage_watchdog_tb;
  import watchdog_pkg::*;
  localparam logic [31:0] IDENT = 32'h0001_0000; // arbitrary value
  localparam logic [ADDR_W-1:0] A_REF = {FRAME_REFRESH, OFS_REFRESH_TRIGGER};
  localparam logic [ADDR_W-1:0] A_RID = {FRAME_REFRESH, OFS_REFRESH_FRAME_IDENT};
  localparam logic [ADDR_W-1:0] A_CS = {FRAME_CONTROL, OFS_CONTROL_AND_ALERT_STATUS};
  localparam logic [ADDR_W-1:0] A_OL = {FRAME_CONTROL, OFS_TIMEOUT_OFFSET_LOW};
  localparam logic [ADDR_W-1:0] A_OH = {FRAME_CONTROL, OFS_TIMEOUT_OFFSET_HIGH};
  localparam logic [ADDR_W-1:0] A_CL = {FRAME_CONTROL, OFS_COMPARE_VALUE_LOW};
  localparam logic [ADDR_W-1:0] A_CH = {FRAME_CONTROL, OFS_COMPARE_VALUE_HIGH};
  localparam logic [ADDR_W-1:0] A_CID = {FRAME_CONTROL, OFS_CONTROL_FRAME_IDENT};
  localparam logic [ADDR_W-1:0] A_RSV = 13'h1004;
  localparam logic [63:0] C0 = 64'h0000_0001_0000_0005;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic warm_n = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic waitreq;
  logic first;
  logic second;
  logic load = 1'b0;
  logic run = 1'b0;
  logic [COUNT_W-1:0] load_val = '0;
  logic [COUNT_W-1:0] count;
  logic [63:0] e64;
  int err_count = 0;
  int checks_done = 0;
  logic [ADDR_W-1:0] src [4] = '{A_REF, A_OL, A_OH, A_CS};
  logic [DATA_W-1:0] sdat [4] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0000, 32'h0000_0001};

  initial begin
    forever #5 clock = ~clock;
  end

  two_stage_watchdog #(.IDENT_VALUE(IDENT)) two_stage_watchdog_inst (
    .CLOCK_I(clock), .RST_N_I(rst_n), .WARM_RST_N_I(warm_n), .SYS_COUNT_I(count),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .FIRST_STAGE_ALERT_O(first), .SECOND_STAGE_ALERT_O(second));

  system_counter_model system_counter_model_inst (.clk_i(clock), .rst_n_i(rst_n),
    .load_i(load), .load_value_i(load_val), .run_i(run), .count_o(count));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // request held until the rising edge where waitrequest is sampled low
  task automatic access(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge clock);
    end while (waitreq !== 1'b0);
    v = rdata; // read data stands at that same edge
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : access

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    access(a, 1'b0, 32'h0000_0000);
    check(v, exp);
  endtask : rd_chk

  // let n edges pass, then look at the settled levels
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : idle

  function automatic logic [31:0] alerts();
    return {30'h0000_0000, second, first};
  endfunction : alerts

  // two compare writes below the counter give two timeouts in a row
  task automatic raise();
    access(A_CL, 1'b1, 32'h0000_0000);
    idle(3);
    access(A_CL, 1'b1, 32'h0000_0000);
    idle(3);
  endtask : raise

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    idle(1);
    foreach (src[i]) rd_chk(src[i], 32'h0000_0000);
    rd_chk(A_CL, 32'h0000_0000);
    check(alerts(), 32'h0000_0000);
    $display("test reset values done");
    access(A_OL, 1'b1, 32'hffff_ffff);
    access(A_OH, 1'b1, 32'habcd_1234);
    rd_chk(A_OH, 32'h0000_1234);
    rd_chk(A_OL, 32'hffff_ffff);
    rd_chk(A_RID, IDENT);
    rd_chk(A_CID, IDENT);
    rd_chk(A_RSV, 32'h0000_0000);
    access(A_CS, 1'b1, 32'hffff_fff8);
    rd_chk(A_CS, 32'h0000_0000);
    $display("test register map done");
    @(posedge clock);
    load <= 1'b1;
    load_val <= C0;
    @(posedge clock);
    load <= 1'b0;
    access(A_REF, 1'b1, 32'h0000_0000);
    e64 = C0 + {16'h0000, 48'h1234_ffff_ffff};
    rd_chk(A_CL, e64[31:0]);
    rd_chk(A_CH, e64[63:32]);
    $display("test explicit reload done");
    access(A_OL, 1'b1, 32'h0000_0010);
    access(A_OH, 1'b1, 32'h0000_0000);
    access(A_CS, 1'b1, 32'h0000_0001);
    idle(1);
    check(alerts(), 32'h0000_0000);
    access(A_CL, 1'b1, 32'h0000_0000);
    idle(3);
    check(alerts(), 32'h0000_0001);
    rd_chk(A_CL, 32'h0000_0015);
    rd_chk(A_CS, 32'h0000_0003);
    access(A_CL, 1'b1, 32'h0000_0000);
    idle(10);
    check(alerts(), 32'h0000_0003);
    rd_chk(A_CL, 32'h0000_0000);
    $display("test two stage timeout done");
    warm_n <= 1'b0;
    idle(2);
    @(posedge clock);
    warm_n <= 1'b1;
    idle(1);
    check(alerts(), 32'h0000_0003);
    rd_chk(A_CS, 32'h0000_0007);
    rd_chk(A_CH, 32'h0000_0001);
    $display("test warm reset done");
    foreach (src[i]) begin
      raise();
      check(alerts(), 32'h0000_0003);
      access(src[i], 1'b1, sdat[i]);
      idle(2);
      check(alerts(), 32'h0000_0000);
    end
    $display("test refresh sources done");
    raise();
    access(A_CS, 1'b1, 32'h0000_0000);
    idle(2);
    check(alerts(), 32'h0000_0000);
    access(A_CL, 1'b1, 32'h0000_0000);
    run <= 1'b1;
    idle(20);
    check(alerts(), 32'h0000_0000);
    @(posedge clock);
    run <= 1'b0;
    access(A_CS, 1'b1, 32'h0000_0001);
    raise();
    @(posedge clock);
    rst_n <= 1'b0;
    idle(2);
    check(alerts(), 32'h0000_0000);
    @(posedge clock);
    rst_n <= 1'b1;
    idle(1);
    rd_chk(A_CS, 32'h0000_0000);
    $display("test disable and cold reset done");
    print_verdict();
  end
endmodule : two_stage_watchdog_tb
